/* spd_dev.sv */
`timescale 1ns/1ps
`include "spd_cfg.svh"
// Overview of operation
// - frame is 8 address plus 24 data bits
// - registers D0H/D2H writable, D1H/D3H readable
// - strobe fall commits write, applied at once
// - ninth clock fall loads output shifter
// - idle lines all held high
// - start on clock fall, strobe low
// - controller limits clock falls under low strobe
// - sample on rise, change on fall
// - controller releases data after read address
// - controller makes dummy transfer after power-up
// - crystal select four rates, reset 3.6MHz
// - reference all ones means standby
// - standby stops divider, amps low, phase hiz
// - reset gives standby, crystal off, inputs
// - swallow divisor range 210H to FFFFH
// - direct mode uses divisor bits 15:4
// - halving mode doubles total division
// - swallow counter 4 bits, main 12 bits
// - direct mode bypasses prescaler
// - 20-bit counter read from D1H
// - pin states apply only with switches all set
// - busy and overflow flags reported
module spd_dev
    import spd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    spd_if.dev bus,
    input wire logic rf_in,
    input wire logic [2:0] cnt_pin_in,
    output logic [23:0] in1_ff,
    output logic [23:0] in2_ff,
    output logic standby_ff,
    output logic xtal_on_ff,
    output logic amp_on_ff,
    output logic div_pulse_ff,
    output logic phase_oe_ff,
    output logic [2:0] pin_out_en_ff
);
    logic [1:0] per_s_ff, clk_s_ff, dat_s_ff;
    logic per_d_ff, clk_d_ff;
    logic [5:0] bitcnt_ff;
    logic [7:0] addr_ff;
    logic [23:0] shin_ff, shout_ff;
    logic rd_ff, drive_ff;
    logic in_frame_ff, cnt_start_ff;
    logic [2:0] cnt_s1_ff, cnt_s2_ff;
    logic [19:0] count_ff, gate_ff;
    logic busy_ff, over_ff;
    logic [16:0] divcnt_ff;
    logic rf_s1_ff, rf_s2_ff, rf_d_ff;
    logic per_fall, clk_fall, clk_rise;
    logic per_high;
    logic [16:0] total_div;
    logic [11:0] direct_div;
    spd_divmode_type dmode;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            per_s_ff <= 2'h3;
            clk_s_ff <= 2'h3;
            dat_s_ff <= 2'h3;
            per_d_ff <= 1'b1;
            clk_d_ff <= 1'b1;
        end else begin
            per_s_ff <= {per_s_ff[0], bus.period};
            clk_s_ff <= {clk_s_ff[0], bus.sclk};
            dat_s_ff <= {dat_s_ff[0], bus.data_line};
            per_d_ff <= per_s_ff[1];
            clk_d_ff <= clk_s_ff[1];
        end
    end
    assign per_fall = per_d_ff && !per_s_ff[1];
    assign per_high = per_s_ff[1];
    assign clk_fall = clk_d_ff && !clk_s_ff[1];
    assign clk_rise = !clk_d_ff && clk_s_ff[1];

    // frame opens on a clock fall under low strobe, ends on strobe fall
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_frame_ff <= 1'b0;
            bitcnt_ff <= 6'h00;
            addr_ff <= 8'h00;
            shin_ff <= 24'h000000;
        end else if (!in_frame_ff) begin
            bitcnt_ff <= 6'h00;
            in_frame_ff <= clk_fall && !per_high;
        end else if (per_fall) begin
            in_frame_ff <= 1'b0;
        end else if (clk_rise && bitcnt_ff < `SPD_FRAME_BITS) begin
            bitcnt_ff <= bitcnt_ff + 6'h01;
            if (bitcnt_ff < {2'h0, `SPD_ADDR_BITS})
                addr_ff <= {addr_ff[6:0], dat_s_ff[1]};
            else
                shin_ff <= {shin_ff[22:0], dat_s_ff[1]};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in1_ff <= `SPD_IN1_RESET;
            in2_ff <= `SPD_IN2_RESET;
            cnt_start_ff <= 1'b0;
        end else begin
            cnt_start_ff <= 1'b0;
            if (in_frame_ff && per_fall &&
                bitcnt_ff == `SPD_FRAME_BITS) begin
                if (addr_ff == `SPD_ADDR_IN1) begin
                    in1_ff <= shin_ff;
                end else if (addr_ff == `SPD_ADDR_IN2) begin
                    in2_ff <= shin_ff;
                    // one-shot start, so a set run bit does not rearm
                    cnt_start_ff <= shin_ff[23];
                end
            end
        end
    end

    // output shifter: load on ninth fall, shift on later falls
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shout_ff <= 24'h000000;
            rd_ff <= 1'b0;
            drive_ff <= 1'b0;
        end else if (!in_frame_ff) begin
            rd_ff <= 1'b0;
            drive_ff <= 1'b0;
        end else if (clk_fall && bitcnt_ff == `SPD_FRAME_BITS - 6'h18) begin
            rd_ff <= addr_ff == `SPD_ADDR_OUT1 || addr_ff == `SPD_ADDR_OUT2;
            drive_ff <= addr_ff == `SPD_ADDR_OUT1 ||
                addr_ff == `SPD_ADDR_OUT2;
            if (addr_ff == `SPD_ADDR_OUT1)
                shout_ff <= {busy_ff, over_ff, count_ff, 2'h0};
            else
                shout_ff <= {5'h00, in2_ff[2:0], cnt_s2_ff,
                    in2_ff[23:11]};
        end else if (clk_fall && rd_ff) begin
            shout_ff <= {shout_ff[22:0], 1'b0};
        end
    end
    assign bus.data_dev_o = shout_ff[23];
    assign bus.data_dev_oe = drive_ff && !shout_ff[23];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            standby_ff <= 1'b1;
            xtal_on_ff <= 1'b0;
            amp_on_ff <= 1'b0;
            phase_oe_ff <= 1'b0;
            pin_out_en_ff <= 3'h0;
        end else begin
            standby_ff <= in1_ff[`SPD_REF_LSB +: 4] == `SPD_STANDBY_REF;
            xtal_on_ff <= in1_ff[`SPD_REF_LSB +: 4] != `SPD_STANDBY_REF;
            amp_on_ff <= !standby_ff;
            phase_oe_ff <= !standby_ff;
            if (&in2_ff[10:8])
                pin_out_en_ff <= in2_ff[7:5];
            else
                pin_out_en_ff <= 3'h0;
        end
    end

    assign dmode = spd_divmode_type'(in1_ff[`SPD_MODE_BIT -: 2]);
    assign direct_div = in1_ff[`SPD_DIV_LSB + 4 +: 12];
    always_comb begin
        total_div = {1'b0, in1_ff[`SPD_DIV_LSB +: 16]};
        if (dmode == spd_div_halve_fm)
            total_div = {in1_ff[`SPD_DIV_LSB +: 16], 1'b0};
        else if (dmode == spd_div_direct_am || dmode == spd_div_direct_fm)
            total_div = {5'h00, direct_div};
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rf_s1_ff <= 1'b0;
            rf_s2_ff <= 1'b0;
            rf_d_ff <= 1'b0;
            cnt_s1_ff <= 3'h0;
            cnt_s2_ff <= 3'h0;
            divcnt_ff <= 17'h00000;
            div_pulse_ff <= 1'b0;
        end else begin
            rf_s1_ff <= rf_in;
            cnt_s1_ff <= cnt_pin_in;
            cnt_s2_ff <= cnt_s1_ff;
            rf_s2_ff <= rf_s1_ff;
            rf_d_ff <= rf_s2_ff;
            div_pulse_ff <= 1'b0;
            if (standby_ff) begin
                divcnt_ff <= 17'h00000;
            end else if (rf_s2_ff && !rf_d_ff) begin
                if (divcnt_ff + 17'h00001 >= total_div) begin
                    divcnt_ff <= 17'h00000;
                    div_pulse_ff <= 1'b1;
                end else begin
                    divcnt_ff <= divcnt_ff + 17'h00001;
                end
            end
        end
    end

    // gate counter: counts rf edges over a fixed window
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= 20'h00000;
            gate_ff <= 20'h00000;
            busy_ff <= 1'b0;
            over_ff <= 1'b0;
        end else if (cnt_start_ff) begin
            busy_ff <= 1'b1;
            gate_ff <= `SPD_GATE_CYCLES;
            count_ff <= 20'h00000;
            over_ff <= 1'b0;
        end else if (busy_ff) begin
            gate_ff <= gate_ff - 20'h00001;
            if (gate_ff == 20'h00000)
                busy_ff <= 1'b0;
            if (rf_s2_ff && !rf_d_ff) begin
                if (&count_ff)
                    over_ff <= 1'b1;
                count_ff <= count_ff + 20'h00001;
            end
        end
    end
endmodule // spd_dev

/* spd_cfg.svh */
`ifndef SPD_CFG_SVH
`define SPD_CFG_SVH
`define SPD_ADDR_IN1 8'hD0
`define SPD_ADDR_OUT1 8'hD1
`define SPD_ADDR_IN2 8'hD2
`define SPD_ADDR_OUT2 8'hD3
`define SPD_ADDR_BITS 4'h8
`define SPD_FRAME_BITS 6'h20
`define SPD_STANDBY_REF 4'hF
`define SPD_IN1_RESET 24'h0000F0
`define SPD_IN2_RESET 24'h000000
`define SPD_REF_LSB 4
`define SPD_XTAL_LSB 0
`define SPD_BAND_BIT 2
`define SPD_MODE_BIT 3
`define SPD_DIV_LSB 8
`define SPD_PS_MIN 16'h0210
`define SPD_DD_MIN 12'h010
`define SPD_HALF_CLK 8'h0C
`define SPD_REG_CTRL 8'h00
`define SPD_REG_WDATA 8'h04
`define SPD_REG_STAT 8'h08
`define SPD_REG_RDATA 8'h0C
`define SPD_GATE_CYCLES 20'h00FFF
`endif

/* spd_pkg.sv */
package spd_pkg;
    typedef enum logic [1:0] {
        spd_xtal_3m6, spd_xtal_4m5, spd_xtal_7m2, spd_xtal_10m8
    } spd_xtal_type;
    typedef enum logic [1:0] {
        spd_div_direct_am, spd_div_swallow_am,
        spd_div_direct_fm, spd_div_halve_fm
    } spd_divmode_type;
endpackage

/* spd_if.sv */
`timescale 1ns/1ps
interface spd_if;
    logic period;
    logic sclk;
    logic data_ctl_o;
    logic data_ctl_oe;
    logic data_dev_o;
    logic data_dev_oe;
    logic data_line;
    assign data_line = (data_ctl_oe && !data_ctl_o) ||
        (data_dev_oe && !data_dev_o) ? 1'b0 : 1'b1;
    modport dev (input period, input sclk, input data_line,
        output data_dev_o, output data_dev_oe);
    modport ctl (output period, output sclk, output data_ctl_o,
        output data_ctl_oe, input data_line);
endinterface

/* spd_ctl.sv */
`timescale 1ns/1ps
`include "spd_cfg.svh"
module spd_ctl
    import spd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    spd_if.ctl bus,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef enum logic [2:0] {
        st_idle, st_low, st_high, st_end, st_rel
    } spd_st_type;
    spd_st_type st_ff;
    logic [31:0] wdata_ff, sh_ff;
    logic [23:0] rdata_ff;
    logic [5:0] bit_ff;
    logic [7:0] div_ff;
    logic busy_ff, rd_ff, per_ff, sclk_ff, do_ff, oe_ff;
    logic [1:0] din_s_ff;
    logic acc;
    assign acc = psel && penable;
    assign bus.period = per_ff;
    assign bus.sclk = sclk_ff;
    assign bus.data_ctl_o = do_ff;
    assign bus.data_ctl_oe = oe_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            wdata_ff <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite) begin
                if (paddr == `SPD_REG_STAT)
                    prdata <= {31'h0, busy_ff};
                else if (paddr == `SPD_REG_RDATA)
                    prdata <= {8'h00, rdata_ff};
                else if (paddr == `SPD_REG_WDATA)
                    prdata <= wdata_ff;
                else
                    prdata <= 32'h00000000;
            end
            if (acc && pwrite && paddr == `SPD_REG_WDATA)
                wdata_ff <= pwdata;
        end
    end

    // frame engine: sclk from divider, data changed on falls
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= st_idle;
            per_ff <= 1'b1;
            sclk_ff <= 1'b1;
            do_ff <= 1'b1;
            oe_ff <= 1'b0;
            busy_ff <= 1'b0;
            rd_ff <= 1'b0;
            sh_ff <= 32'h00000000;
            bit_ff <= 6'h00;
            div_ff <= 8'h00;
            rdata_ff <= 24'h000000;
            din_s_ff <= 2'h3;
        end else begin
            din_s_ff <= {din_s_ff[0], bus.data_line};
            div_ff <= (div_ff == `SPD_HALF_CLK) ? 8'h00 : div_ff + 8'h01;
            case (st_ff)
                st_idle: begin
                    oe_ff <= 1'b0;
                    if (acc && pwrite && paddr == `SPD_REG_CTRL && !busy_ff) begin
                        busy_ff <= 1'b1;
                        sh_ff <= wdata_ff;
                        rd_ff <= wdata_ff[31:24] == `SPD_ADDR_OUT1 ||
                            wdata_ff[31:24] == `SPD_ADDR_OUT2;
                        bit_ff <= 6'h00;
                        per_ff <= 1'b0;
                        div_ff <= 8'h00;
                        st_ff <= st_high;
                    end
                end
                st_high: if (div_ff == `SPD_HALF_CLK) begin
                    sclk_ff <= 1'b0;
                    if (rd_ff && bit_ff >= {2'h0, `SPD_ADDR_BITS}) begin
                        oe_ff <= 1'b0;
                    end else begin
                        oe_ff <= 1'b1;
                        do_ff <= sh_ff[31];
                    end
                    sh_ff <= {sh_ff[30:0], 1'b0};
                    st_ff <= st_low;
                end
                st_low: if (div_ff == `SPD_HALF_CLK) begin
                    sclk_ff <= 1'b1;
                    // strobe goes high after the opening fall
                    if (bit_ff == 6'h00)
                        per_ff <= 1'b1;
                    if (rd_ff && bit_ff >= {2'h0, `SPD_ADDR_BITS})
                        rdata_ff <= {rdata_ff[22:0], din_s_ff[1]};
                    bit_ff <= bit_ff + 6'h01;
                    st_ff <= (bit_ff == `SPD_FRAME_BITS - 6'h01) ? st_end
                        : st_high;
                end
                st_end: if (div_ff == `SPD_HALF_CLK) begin
                    per_ff <= 1'b0;
                    do_ff <= 1'b1;
                    oe_ff <= 1'b0;
                    st_ff <= st_rel;
                end
                default: if (div_ff == `SPD_HALF_CLK) begin
                    per_ff <= 1'b1;
                    busy_ff <= 1'b0;
                    st_ff <= st_idle;
                end
            endcase
        end
    end
endmodule // spd_ctl

/* spd_link_monitor.sv */
`timescale 1ns/1ps
module spd_link_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic period,
    input wire logic sclk,
    input wire logic data_ctl_o,
    input wire logic data_ctl_oe,
    input wire logic data_dev_o,
    input wire logic data_dev_oe,
    input wire logic data_line
);
    logic sclk_ff, period_ff, frm_ff, sclk_fall;
    logic [5:0] rises_ff, low_falls_ff;
    assign sclk_fall = sclk_ff && !sclk;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_ff <= 1'b1;
            period_ff <= 1'b1;
        end else begin
            sclk_ff <= sclk;
            period_ff <= period;
        end
    end
    // frame opens on a clock fall under low strobe, ends on a strobe fall
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            frm_ff <= 1'b0;
        end else if (!frm_ff) begin
            frm_ff <= sclk_fall && !period;
        end else if (period_ff && !period) begin
            frm_ff <= 1'b0;
        end
    end
    // counts only inside a frame
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rises_ff <= 6'h00;
        end else if (!frm_ff) begin
            rises_ff <= 6'h00;
        end else begin
            rises_ff <= rises_ff + {5'h00, sclk && !sclk_ff};
        end
    end
    // falls under low strobe, the opening fall included
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            low_falls_ff <= 6'h00;
        end else if (sclk_fall && !period) begin
            low_falls_ff <= low_falls_ff + 6'h01;
        end else if (!frm_ff) begin
            low_falls_ff <= 6'h00;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_idle_clock_high: assert property (!frm_ff && period |-> sclk)
        else $error("clock not high while idle");
    a_idle_data_high: assert property (!frm_ff && period |-> data_line)
        else $error("data not high while idle");
    a_dev_idle_quiet: assert property (
        !frm_ff && period |-> !data_dev_oe)
        else $error("device drives data outside a frame");
    a_no_contention: assert property (!(data_ctl_oe && data_dev_oe))
        else $error("both ends drive data");
    a_frame_length: assert property (
        $fell(period) && frm_ff |-> rises_ff == 6'h20)
        else $error("frame did not carry 32 clock rises");
    a_end_clock_high: assert property (
        $fell(period) && frm_ff |-> sclk && $past(sclk))
        else $error("frame ended with clock low");
    a_low_strobe_falls: assert property (low_falls_ff <= 6'h08)
        else $error("too many clock falls under low strobe");
    // release of the address driver lands on the ninth fall, after the eighth rise
    a_data_setup: assert property (
        $rose(sclk) && rises_ff != 6'h07 |-> $stable(data_line))
        else $error("data moved at a clock rise");
    a_low_phase: assert property ($fell(sclk) |-> !sclk [*8])
        else $error("clock low phase too short");
    a_dev_drive_late: assert property (
        $rose(data_dev_oe) |-> rises_ff >= 6'h08)
        else $error("device drove data during the address");
endmodule // spd_link_monitor

/* testbench.sv */
`timescale 1ns/1ps
`include "spd_cfg.svh"
module testbench;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, rf_in;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [2:0] cnt_pin_in, pin_out_en;
    logic [23:0] in1, in2, rd, v;
    logic standby, xtal_on, amp_on, div_pulse, phase_oe;
    logic [7:0] tick;
    int mismatches, n_checks, k;
    spd_if bus_if();
    spd_dev u_spd_dev (.mclk(mclk), .rst_n(rst_n), .bus(bus_if),
        .rf_in(rf_in), .cnt_pin_in(cnt_pin_in), .in1_ff(in1),
        .in2_ff(in2), .standby_ff(standby), .xtal_on_ff(xtal_on),
        .amp_on_ff(amp_on), .div_pulse_ff(div_pulse),
        .phase_oe_ff(phase_oe), .pin_out_en_ff(pin_out_en));
    spd_ctl u_spd_ctl (.mclk(mclk), .rst_n(rst_n), .bus(bus_if),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    spd_link_monitor u_spd_link_monitor (.mclk(mclk), .rst_n(rst_n),
        .period(bus_if.period), .sclk(bus_if.sclk),
        .data_ctl_o(bus_if.data_ctl_o), .data_ctl_oe(bus_if.data_ctl_oe),
        .data_dev_o(bus_if.data_dev_o), .data_dev_oe(bus_if.data_dev_oe),
        .data_line(bus_if.data_line));
    always #2.5 mclk = ~mclk;
    // slow toggling keeps divider and counter inputs busy
    always @(posedge mclk) begin
        tick <= tick + 8'h01;
        rf_in <= tick[2];
        cnt_pin_in <= tick[7:5];
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic count_pulses(input int cycles, output int cnt);
        cnt = 0;
        repeat (cycles) begin
            @(posedge mclk);
            if (div_pulse === 1'b1)
                cnt++;
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            give_verdict();
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic frame(input logic [7:0] a, input logic [23:0] d,
            output logic [23:0] q);
        logic [31:0] s;
        int n;
        n = 0;
        apb(1'b1, `SPD_REG_WDATA, {a, d}, s);
        apb(1'b1, `SPD_REG_CTRL, 32'h00000001, s);
        do begin
            apb(1'b0, `SPD_REG_STAT, 32'h00000000, s);
            n++;
        end while (s[0] !== 1'b0 && n < 1000);
        if (n >= 1000) begin
            mismatches++;
            give_verdict();
        end
        apb(1'b0, `SPD_REG_RDATA, 32'h00000000, s);
        q = s[23:0];
    endtask
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        rf_in = 1'b0;
        cnt_pin_in = 3'h0;
        tick = 8'h00;
        mismatches = 0;
        n_checks = 0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk(standby, 1'b1);
        chk(xtal_on, 1'b0);
        chk(in1, `SPD_IN1_RESET);
        chk(in2, `SPD_IN2_RESET);
        chk(pin_out_en, 3'h0);
        chk(phase_oe, 1'b0);
        chk(amp_on, 1'b0);
        frame(`SPD_ADDR_OUT2, 24'h000000, rd);
        for (int i = 0; i < 4; i++) begin
            v = {16'h0210, 4'h1, 2'b00, i[1:0]};
            frame(`SPD_ADDR_IN1, v, rd);
            chk(in1, v);
            frame(`SPD_ADDR_OUT1, 24'h000000, rd);
            chk(rd, 24'h000000);
            chk(in1[1:0], i[1:0]);
            chk(standby, 1'b0);
        end
        // rf edge every 8 clocks; windows hold whole divider periods
        count_pulses(1056, k);
        chk(k, 4);
        frame(`SPD_ADDR_IN1, 24'h021015, rd);
        count_pulses(8448, k);
        chk(k, 2);
        frame(`SPD_ADDR_IN1, 24'h02101D, rd);
        count_pulses(8448, k);
        chk(k, 1);
        frame(`SPD_ADDR_IN1, 24'hFFF0FB, rd);
        chk(in1, 24'hFFF0FB);
        frame(`SPD_ADDR_IN1, 24'hFFFFF3, rd);
        chk(in1, 24'hFFFFF3);
        frame(`SPD_ADDR_OUT2, 24'h000000, rd);
        chk(rd[12:0], 13'h0000);
        chk(standby, 1'b1);
        chk(amp_on, 1'b0);
        chk(phase_oe, 1'b0);
        count_pulses(600, k);
        chk(k, 0);
        frame(8'hD5, 24'h123456, rd);
        frame(8'hCF, 24'h654321, rd);
        frame(`SPD_ADDR_OUT1, 24'h000000, rd);
        chk(in1, 24'hFFFFF3);
        chk(in2, `SPD_IN2_RESET);
        frame(`SPD_ADDR_IN2, 24'h8007A0, rd);
        chk(pin_out_en, 3'h5);
        frame(`SPD_ADDR_OUT2, 24'h000000, rd);
        chk(rd[12:0], 13'h1000);
        v = 24'h800000;
        for (int i = 0; i < 20 && v[23] !== 1'b0; i++) begin
            frame(`SPD_ADDR_OUT1, 24'h000000, v);
        end
        chk(in2, 24'h8007A0);
        chk(v[23], 1'b0);
        chk(v[22], 1'b0);
        // gate window spans whole rf periods of 8 clocks
        chk(v[21:2], (`SPD_GATE_CYCLES + 20'h00001) >> 3);
        chk(v[1:0], 2'b00);
        apb(1'b0, 8'h10, 32'h00000000, r);
        chk(r, 32'h00000000);
        chk(pslverr, 1'b0);
        give_verdict();
    end
endmodule // testbench
